// [design/lsl_pkg.sv]
`default_nettype none
package lsl_pkg;
  localparam int LSL_OUTPUTS = 160;
  localparam int LSL_NIBBLE_W = 4;
  localparam int LSL_NIBBLES_PER_LINE = 40;
  localparam int LSL_FIFO_DEPTH = 8;
  localparam int LSL_LEVEL_W = 2;
  localparam int LSL_CNT_W = 6;
  // Drive level codes per segment
  localparam logic [1:0] LSL_LVL_ONE = 2'h0;
  localparam logic [1:0] LSL_LVL_THREE = 2'h1;
  localparam logic [1:0] LSL_LVL_FOUR = 2'h2;
  localparam logic [1:0] LSL_LVL_LOWEST = 2'h3;
  localparam logic [5:0] LSL_CNT_RESET = 6'h00;
  localparam logic [5:0] LSL_LINE_FULL = 6'h28;
endpackage : lsl_pkg
`default_nettype wire

// [design/lsl_fifo.sv]
`default_nettype none
module lsl_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wptr_r;
  logic [AW:0] rptr_r;
  logic push;
  logic pop;

  assign in_ready = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wptr_r != rptr_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rptr_r[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule : lsl_fifo
`default_nettype wire

// [design/lsl_loader.sv]
`default_nettype none
// Function
// - Nibble taken on data clock falling edge
// - Two 160-bit latches, second drives outputs
// - Strobe falling edge copies whole first latch
// - Direction picks chain port input and output
// - Direction low fills from last output
// - Direction high fills from first output
// - Latch bit and polarity select level
// - Blanking low forces level one
// - Unselected driver keeps fetch logic idle
module lsl_loader
  import lsl_pkg::*;
#(
  parameter int OUTPUTS = LSL_OUTPUTS,
  parameter int NIBBLES = LSL_NIBBLES_PER_LINE,
  parameter int FIFO_DEPTH = LSL_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic data_clock,
  input wire logic [3:0] pixel_nibble,
  input wire logic line_strobe,
  input wire logic shift_direction,
  input wire logic frame_polarity,
  input wire logic blanking,
  input wire logic chain_port_a_in,
  output logic chain_port_a_out,
  output logic chain_port_a_oe,
  input wire logic chain_port_b_in,
  output logic chain_port_b_out,
  output logic chain_port_b_oe,
  output logic stream_ready,
  output logic [2*OUTPUTS-1:0] segment_outputs
);
  ////////////////////////////////////////////////////////////////
  localparam int SW = 11;
  localparam int B_CP = 10;
  localparam int B_LD = 9;
  localparam int B_DIR = 8;
  localparam int B_DF = 7;
  localparam int B_BL = 6;
  localparam int B_A = 5;
  localparam int B_B = 4;

  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [1:0] s3_r;
  logic cp_fall;
  logic ld_fall;
  logic dir;
  logic chain_in;
  logic [5:0] fill_cnt_r;
  logic take;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [4:0] fifo_in_data;
  logic [4:0] fifo_out_data;
  logic [5:0] drain_idx_r;
  logic copy_r;
  logic drain_pop;
  logic latch1_we;
  logic [OUTPUTS-1:0] latch1_r;
  logic [OUTPUTS-1:0] latch2_r;
  logic [2*OUTPUTS-1:0] seg_r;

  // Bit position of nibble bit i for nibble k in the line
  function automatic int place(input logic [5:0] k, input logic d, input int i);
    if (d) begin
      place = 4 * int'(k) + 3 - i;
    end else begin
      place = OUTPUTS - 4 - 4 * int'(k) + i;
    end
  endfunction : place

  // Level code from frame polarity and latch bit
  function automatic logic [1:0] level_of(input logic df, input logic bit_v);
    unique case ({df, bit_v})
      2'b00: level_of = LSL_LVL_THREE;
      2'b01: level_of = LSL_LVL_ONE;
      2'b10: level_of = LSL_LVL_FOUR;
      2'b11: level_of = LSL_LVL_LOWEST;
    endcase
  endfunction : level_of

  ////////////////////////////////////////////////////////////////
  // Pins pass two flops; edges are seen only on the second stage
  // No reset here: reset outlasts the two stages
  always_ff @(posedge mclk) begin
    s1_r <= {
      data_clock,
      line_strobe,
      shift_direction,
      frame_polarity,
      blanking,
      chain_port_a_in,
      chain_port_b_in,
      pixel_nibble
    };
    s2_r <= s1_r;
    s3_r <= {s2_r[B_CP], s2_r[B_LD]};
  end

  assign cp_fall = s3_r[1] & ~s2_r[B_CP];
  assign ld_fall = s3_r[0] & ~s2_r[B_LD];
  assign dir = s2_r[B_DIR];

  ////////////////////////////////////////////////////////////////
  // port roles by direction
  assign chain_in = dir ? s2_r[B_A] : s2_r[B_B];
  assign chain_port_a_oe = ~dir;
  assign chain_port_b_oe = dir;
  assign chain_port_a_out = fill_cnt_r != LSL_LINE_FULL;
  assign chain_port_b_out = fill_cnt_r != LSL_LINE_FULL;

  assign take = cp_fall & ~chain_in & (fill_cnt_r < 6'(NIBBLES));

  // Starts full: nothing is taken and the chain passes on until a strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      fill_cnt_r <= LSL_LINE_FULL;
    end else if (ld_fall) begin
      fill_cnt_r <= LSL_CNT_RESET;
    end else if (take & stream_ready) begin
      fill_cnt_r <= fill_cnt_r + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Strobe travels as a marker word so it keeps its place among nibbles
  assign fifo_in_valid = take | ld_fall;
  assign fifo_in_data = {ld_fall, s2_r[3:0]};
  // A copy cycle holds the drain so a new nibble cannot overtake it
  assign fifo_out_ready = ~copy_r;
  // One pop per cycle; a marker pop stalls the next one
  assign drain_pop = fifo_out_valid & fifo_out_ready;
  assign latch1_we = drain_pop & ~fifo_out_data[4] & (drain_idx_r < 6'(NIBBLES));

  // Eight words absorb the one-cycle copy stall with room to spare
  lsl_fifo #(
    .WIDTH(5),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(stream_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      copy_r <= 1'b0;
      drain_idx_r <= LSL_CNT_RESET;
    end else begin
      copy_r <= drain_pop & fifo_out_data[4];
      if (drain_pop) begin
        if (fifo_out_data[4]) begin
          drain_idx_r <= LSL_CNT_RESET;
        end else if (drain_idx_r < 6'(NIBBLES)) begin
          drain_idx_r <= drain_idx_r + 6'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Direction is read at drain time, so hold it steady within a line
  // first latch fill
  always_ff @(posedge mclk) begin
    if (rst) begin
      latch1_r <= '0;
    end else if (latch1_we) begin
      for (int i = 0; i < LSL_NIBBLE_W; i++) begin
        latch1_r[place(drain_idx_r, dir, i)] <= fifo_out_data[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      latch2_r <= '0;
    end else if (copy_r) begin
      latch2_r <= latch1_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      seg_r <= '0;
    end else begin
      for (int j = 0; j < OUTPUTS; j++) begin
        if (!s2_r[B_BL]) begin
          seg_r[2*j +: 2] <= LSL_LVL_ONE;
        end else begin
          seg_r[2*j +: 2] <= level_of(s2_r[B_DF], latch2_r[j]);
        end
      end
    end
  end

  assign segment_outputs = seg_r;
endmodule : lsl_loader
`default_nettype wire

// [tb/lsl_loader_sva.sv]
`default_nettype none
module lsl_loader_sva #(parameter int OUTPUTS = 160) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic line_strobe,
  input wire logic shift_direction,
  input wire logic frame_polarity,
  input wire logic blanking,
  input wire logic chain_port_b_in,
  input wire logic chain_port_a_out,
  input wire logic chain_port_b_out,
  input wire logic chain_port_a_oe,
  input wire logic chain_port_b_oe,
  input wire logic [2*OUTPUTS-1:0] segment_outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_oe_excl: assert property (chain_port_a_oe != chain_port_b_oe) else $error("oe clash");
  chk_oe_dir: assert property (
    $stable(shift_direction)[*4] |-> chain_port_b_oe == shift_direction) else $error("oe dir");
  chk_chain_same: assert property (chain_port_a_out == chain_port_b_out) else $error("chain");
  // Sync plus output register, so five samples of margin
  chk_blank_lvl: assert property (!blanking[*5] |-> segment_outputs == '0) else $error("blank");
  chk_outputs_hold: assert property (
    (blanking && $stable(line_strobe) && $stable(frame_polarity))[*8] |-> $stable(segment_outputs))
    else $error("hold");
  chk_strobe_high: assert property ($fell(line_strobe) |-> ##[2:6] chain_port_a_out) else $error("strb");
  chk_refuse_high: assert property (
    (!shift_direction && chain_port_b_in)[*6] |-> !$fell(chain_port_a_out)) else $error("refuse");
  chk_reset_full: assert property (
    $fell(rst) |-> !chain_port_a_out && segment_outputs == '0) else $error("reset");
  cover property ($fell(chain_port_a_out));
  cover property ($fell(line_strobe));
  cover property (!blanking);
endmodule : lsl_loader_sva
bind lsl_loader lsl_loader_sva #(.OUTPUTS(OUTPUTS)) u_sva (
  .mclk(mclk),
  .rst(rst),
  .line_strobe(line_strobe),
  .shift_direction(shift_direction),
  .frame_polarity(frame_polarity),
  .blanking(blanking),
  .chain_port_b_in(chain_port_b_in),
  .chain_port_a_out(chain_port_a_out),
  .chain_port_b_out(chain_port_b_out),
  .chain_port_a_oe(chain_port_a_oe),
  .chain_port_b_oe(chain_port_b_oe),
  .segment_outputs(segment_outputs)
);
`default_nettype wire

// [tb/lsl_ctrl_model.sv]
`default_nettype none
module lsl_ctrl_model (
  input wire logic mclk,
  output logic data_clock = 1'h0,
  output logic [3:0] pixel_nibble = 4'h0,
  output logic line_strobe = 1'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : wt
  // Data held 3 cycles past the fall, then scrambled so stale data never matches
  task automatic nib(input logic [3:0] d, input int w);
    pixel_nibble = d;
    data_clock = 1'h1;
    wt(w);
    data_clock = 1'h0;
    wt(3);
    pixel_nibble = ~d;
    wt(w - 2);
  endtask : nib
  task automatic ld();
    line_strobe = 1'h1;
    wt(4);
    line_strobe = 1'h0;
    wt(4);
  endtask : ld
endmodule : lsl_ctrl_model
`default_nettype wire

// [tb/lsl_loader_tb.sv]
`default_nettype none
module lsl_loader_tb;
  import lsl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst = 1, dir = 0, fp = 0, bl = 1, en = 0;
  logic a_o, a_oe, b_o, b_oe, a_w, b_w, dclk, strb, rdy;
  logic [3:0] nb;
  logic [319:0] seg;
  logic [159:0] lb = '0;
  int n_fail = 0, total_checks = 0;
  assign a_w = a_oe ? a_o : en;
  assign b_w = b_oe ? b_o : en;
  lsl_ctrl_model u (.mclk(mclk), .data_clock(dclk), .pixel_nibble(nb), .line_strobe(strb));
  lsl_loader DUT (.mclk(mclk), .rst(rst), .data_clock(dclk), .pixel_nibble(nb), .line_strobe(strb),
    .shift_direction(dir), .frame_polarity(fp), .blanking(bl), .chain_port_a_in(a_w), .chain_port_a_out(a_o),
    .chain_port_a_oe(a_oe), .chain_port_b_in(b_w), .chain_port_b_out(b_o), .chain_port_b_oe(b_oe),
    .stream_ready(rdy), .segment_outputs(seg));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic cmp(input logic [319:0] g, input logic [319:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  function automatic logic [319:0] lvl();
    logic [319:0] r;
    for (int n = 0; n < 160; n++) r[2*n+:2] = !bl ? LSL_LVL_ONE :
      fp ? (lb[n] ? LSL_LVL_LOWEST : LSL_LVL_FOUR) : (lb[n] ? LSL_LVL_ONE : LSL_LVL_THREE);
    return r;
  endfunction : lvl
  // Two spare nibbles per line must be dropped, keeping the count even
  task automatic t_line(input logic d, input logic e);
    int o;
    dir = d;
    en = e;
    u.ld();
    cmp(d ? b_o : a_o, 1);
    for (int k = 0; k < 42; k++) begin
      for (int i = 0; i < 4; i++) begin
        o = d ? 4 + 4 * k - i : 157 - 4 * k + i;
        if (!e && k < 40) lb[o - 1] = 1'((k * 7) >> i);
      end
      u.nib(4'(k * 7), 4 + 2 * d);
    end
    cmp(d ? b_o : a_o, e);
    cmp(b_oe, d);
    cmp(a_oe, !d);
    u.ld();
    u.wt(6);
    cmp(seg, lvl());
    $display("t_line %0d%0d done", d, e);
  endtask : t_line
  task automatic t_level();
    for (int m = 0; m < 4; m++) begin
      {bl, fp} = 2'(m);
      u.wt(8);
      cmp(seg, lvl());
    end
    $display("t_level done");
  endtask : t_level
  // Mid-run reset empties both latches and parks the chain
  task automatic t_reset();
    rst = 1;
    u.wt(4);
    rst = 0;
    lb = '0;
    u.wt(3);
    cmp(a_o, 0);
    cmp(rdy, 1);
    cmp(seg, lvl());
    $display("t_reset done");
  endtask : t_reset
  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    u.wt(20);
    rst = 0;
    u.wt(3);
    cmp(a_o, 0);
    t_line(0, 0);
    t_level();
    t_line(1, 0);
    t_line(0, 1);
    t_line(1, 0);
    t_reset();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    final_report();
  end
endmodule : lsl_loader_tb
`default_nettype wire
